/* File: src/pmcs_pkg.sv */
// constants and types for the mac mode and crossover select block
package pmcs_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ     = 25;
  localparam int INIT_US     = 2;
  localparam int INIT_CYC    = INIT_US * CLK_MHZ;
  localparam int HUNT_US     = 1000;
  localparam int HUNT_CYC    = HUNT_US * CLK_MHZ;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  // ---------------------------------------------------------------
  // register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam int CTRL_RESTART  = 0;
  localparam int CTRL_HUNT_EN  = 1;
  localparam logic CTRL_HUNT_RST = 1'b1;
  localparam int ST_LINK       = 0;
  localparam int ST_SPEED      = 1;
  localparam int ST_DUPLEX     = 3;
  localparam int ST_MDIX       = 4;
  localparam int ST_MODE       = 5;
  localparam int ST_IN_RESET   = 8;
  localparam int ST_LINK_CHG   = 9;
  localparam int CFG_TEN_BIT   = 0;
  localparam int CFG_SER_TEN   = 1;
  localparam int CFG_XMODE     = 2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_MII10  = 3'b000,
    MODE_SERIAL = 3'b001,
    MODE_MII100 = 3'b010,
    MODE_GMII   = 3'b011,
    MODE_TBI    = 3'b100
  } pmcs_mode_t;

  typedef enum logic [1:0] {
    RATE_2M5  = 2'b00,
    RATE_10M  = 2'b01,
    RATE_25M  = 2'b10,
    RATE_125M = 2'b11
  } pmcs_rate_t;

  typedef enum logic [1:0] {
    SPD_10   = 2'b00,
    SPD_100  = 2'b01,
    SPD_1000 = 2'b10
  } pmcs_speed_t;

  typedef enum logic [1:0] {
    XO_MDI  = 2'b00,
    XO_MDIX = 2'b01,
    XO_AUTO = 2'b10
  } pmcs_xmode_t;

  typedef enum logic [1:0] {
    ST_HOLD    = 2'b00,
    ST_RESTART = 2'b01,
    ST_RUN     = 2'b10
  } pmcs_init_t;

  localparam logic [3:0] W_SER  = 4'h1;
  localparam logic [3:0] W_NIB  = 4'h4;
  localparam logic [3:0] W_BYTE = 4'h8;
  localparam logic [3:0] W_TEN  = 4'hA;

endpackage : pmcs_pkg

/* File: src/pmcs_top.sv */
// mac interface mode selection, pair crossover steering and link status
`timescale 1ns/1ns
`default_nettype none

// Operation
// - strap low gives gigabit, fast, ten speeds
// - strap high gives ten-bit gigabit only
// - gigabit link uses eight bits, 125 MHz
// - hundred link uses nibble at 25 MHz
// - ten link uses nibble or serial path
// - ten-bit mode: 125 MHz, no fallback
// - no link outside ten-bit mode runs clocks as ten nibble
// - crossover low transmits A, receives B
// - crossover high transmits B, receives A
// - crossover open detects pair mapping automatically
// - slow links and negotiation idle C, D
// - gigabit uses all four pairs both ways
// - gigabit pair roles ignore crossover setting
// - power-up and reset run same sequence
// - report link up, speed and duplex
// - serial strap high picks serial ten mode
// - crossover change forces reset and renegotiation
// - crossover applied only below gigabit
module pmcs_top
  import pmcs_pkg::*;
#(
  parameter int HUNT_CYCLES = HUNT_CYC
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  // configuration pins
  input  wire logic        ten_bit_config_strap_i,
  input  wire logic        serial_ten_select_i,
  input  wire logic        crossover_select_i,
  input  wire logic        crossover_open_i,
  // receive pair activity clock from the line
  input  wire logic        rx_pair_clk_i,
  // resolved link from the negotiation engine
  input  wire logic        link_up_i,
  input  wire logic [1:0]  link_speed_i,
  input  wire logic        link_duplex_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic      [31:0] reg_rdata_o,
  // mac interface mode
  output logic      [2:0]  mac_mode_o,
  output logic      [3:0]  mac_width_o,
  output logic      [1:0]  mac_rate_o,
  // pair steering
  output logic             pair_a_tx_o,
  output logic             pair_a_rx_o,
  output logic             pair_b_tx_o,
  output logic             pair_b_rx_o,
  output logic             pair_cd_on_o,
  // internal reset and negotiation restart
  output logic             phy_reset_o,
  output logic             an_restart_o
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic       rxc_s1_q;
  logic       rxc_s2_q;
  logic       rxc_s3_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end else begin
      pin_s1_q <= {crossover_open_i, crossover_select_i,
                   serial_ten_select_i, ten_bit_config_strap_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  // link clock sampled like any pin; third stage finds edges
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rxc_s1_q <= 1'b0;
      rxc_s2_q <= 1'b0;
      rxc_s3_q <= 1'b0;
    end else begin
      rxc_s1_q <= rx_pair_clk_i;
      rxc_s2_q <= rxc_s1_q;
      rxc_s3_q <= rxc_s2_q;
    end
  end

  logic rx_edge;
  assign rx_edge = rxc_s2_q ^ rxc_s3_q;

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  logic [1:0] strap_cnt_q;
  logic       strap_done_q;
  logic       ten_bit_q;
  logic       ser_ten_q;

  // waits out the synchroniser, then freezes the straps
  // latch straps once
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
      ten_bit_q    <= 1'b0;
      ser_ten_q    <= 1'b0;
    end else if (!strap_done_q) begin
      if (strap_cnt_q == STRAP_WAIT) begin
        strap_done_q <= 1'b1;
        ten_bit_q    <= pin_s2_q[0];
        ser_ten_q    <= pin_s2_q[1];
      end else begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // crossover select decode and change detect
  // ---------------------------------------------------------------
  pmcs_xmode_t xmode;
  pmcs_xmode_t xmode_q;
  logic        xmode_chg;

  // open pin wins over the level it happens to float at
  always_comb begin
    if (pin_s2_q[3]) begin
      xmode = XO_AUTO;
    end else if (pin_s2_q[2]) begin
      xmode = XO_MDIX;
    end else begin
      xmode = XO_MDI;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xmode_q <= XO_MDI;
    end else begin
      xmode_q <= xmode;
    end
  end

  assign xmode_chg = strap_done_q && (xmode != xmode_q);

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  logic soft_restart;
  logic hunt_en_q;
  logic wr_ctrl;
  logic wr_stat;

  assign wr_ctrl      = reg_we_i && (reg_addr_i == ADDR_CTRL);
  assign wr_stat      = reg_we_i && (reg_addr_i == ADDR_STATUS);
  assign soft_restart = wr_ctrl && reg_wdata_i[CTRL_RESTART];

  // hunt enable lets software pin auto mode to straight pairs
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hunt_en_q <= CTRL_HUNT_RST;
    end else if (wr_ctrl) begin
      hunt_en_q <= reg_wdata_i[CTRL_HUNT_EN];
    end
  end

  // ---------------------------------------------------------------
  // initialisation sequence
  // ---------------------------------------------------------------
  pmcs_init_t  init_q;
  logic [7:0]  init_cnt_q;
  localparam logic [7:0] INIT_LAST = 8'(INIT_CYC - 1);

  // power-up and hardware reset both enter here through rstn_i
  // one reset sequence
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      init_q     <= ST_HOLD;
      init_cnt_q <= 8'h00;
    end else if (xmode_chg || soft_restart) begin
      init_q     <= ST_HOLD;
      init_cnt_q <= 8'h00;
    end else begin
      unique case (init_q)
        ST_HOLD: begin
          if (strap_done_q && (init_cnt_q == INIT_LAST)) begin
            init_q <= ST_RESTART;
          end else if (init_cnt_q != INIT_LAST) begin
            init_cnt_q <= init_cnt_q + 8'h01;
          end
        end
        ST_RESTART: begin
          init_q <= ST_RUN;
        end
        ST_RUN: begin
          init_q <= ST_RUN;
        end
        default: begin
          init_q <= ST_HOLD;
        end
      endcase
    end
  end

  assign phy_reset_o  = (init_q == ST_HOLD);
  assign an_restart_o = (init_q == ST_RESTART);

  // ---------------------------------------------------------------
  // link status
  // ---------------------------------------------------------------
  logic        link_q;
  pmcs_speed_t speed_q;
  logic        duplex_q;
  logic        link_chg_q;
  logic        link_ok;

  // ten-bit mode has no fallback, so a slow link is no link
  // no lower speed
  assign link_ok = link_up_i && (init_q == ST_RUN) &&
                   (!ten_bit_q || (link_speed_i == SPD_1000));

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_q   <= 1'b0;
      speed_q  <= SPD_10;
      duplex_q <= 1'b0;
    end else begin
      link_q   <= link_ok;
      speed_q  <= pmcs_speed_t'(link_speed_i);
      duplex_q <= link_duplex_i;
    end
  end

  // a change in the same cycle as the clear keeps the flag set
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_chg_q <= 1'b0;
    end else if (link_ok != link_q) begin
      link_chg_q <= 1'b1;
    end else if (wr_stat && reg_wdata_i[ST_LINK_CHG]) begin
      link_chg_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // automatic crossover hunt
  // ---------------------------------------------------------------
  logic [15:0] hunt_cnt_q;
  logic        activity_q;
  logic        mdix_auto_q;
  logic        hunt_end;
  logic        hunting;
  localparam logic [15:0] HUNT_LAST = 16'(HUNT_CYCLES - 1);

  assign hunt_end = (hunt_cnt_q == HUNT_LAST);
  assign hunting  = (xmode_q == XO_AUTO) && hunt_en_q &&
                    !link_q && (init_q == ST_RUN);

  // window counter and edge seen within the window
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hunt_cnt_q <= 16'h0000;
      activity_q <= 1'b0;
    end else if (!hunting || hunt_end) begin
      hunt_cnt_q <= 16'h0000;
      activity_q <= 1'b0;
    end else begin
      hunt_cnt_q <= hunt_cnt_q + 16'h0001;
      activity_q <= activity_q | rx_edge;
    end
  end

  // swap pairs at each quiet window; keep a mapping that hears
  // auto pair detect
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mdix_auto_q <= 1'b0;
    end else if ((xmode_q == XO_AUTO) && !hunt_en_q) begin
      mdix_auto_q <= 1'b0;
    end else if (hunting && hunt_end && !activity_q && !rx_edge) begin
      mdix_auto_q <= !mdix_auto_q;
    end
  end

  logic mdix;

  always_comb begin
    unique case (xmode_q)
      XO_MDI:  mdix = 1'b0;
      XO_MDIX: mdix = 1'b1;
      XO_AUTO: mdix = mdix_auto_q;
      default: mdix = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // pair steering
  // ---------------------------------------------------------------
  logic gig;
  assign gig = link_q && (speed_q == SPD_1000);

  // held idle while in reset so nothing drives the line
  // four pairs both ways
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pair_a_tx_o  <= 1'b0;
      pair_a_rx_o  <= 1'b0;
      pair_b_tx_o  <= 1'b0;
      pair_b_rx_o  <= 1'b0;
      pair_cd_on_o <= 1'b0;
    end else if (init_q == ST_HOLD) begin
      pair_a_tx_o  <= 1'b0;
      pair_a_rx_o  <= 1'b0;
      pair_b_tx_o  <= 1'b0;
      pair_b_rx_o  <= 1'b0;
      pair_cd_on_o <= 1'b0;
    end else if (gig) begin
      pair_a_tx_o  <= 1'b1;
      pair_a_rx_o  <= 1'b1;
      pair_b_tx_o  <= 1'b1;
      pair_b_rx_o  <= 1'b1;
      pair_cd_on_o <= 1'b1;
    end else begin
      pair_a_tx_o  <= !mdix;
      pair_a_rx_o  <= mdix;
      pair_b_tx_o  <= mdix;
      pair_b_rx_o  <= !mdix;
      pair_cd_on_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // mac interface mode resolve
  // ---------------------------------------------------------------
  pmcs_mode_t mode_d;

  // no link outside ten-bit mode acts as ten nibble
  always_comb begin
    if (ten_bit_q) begin
      mode_d = MODE_TBI;
    end else if (!link_q) begin
      mode_d = MODE_MII10;
    end else begin
      unique case (speed_q)
        SPD_1000: mode_d = MODE_GMII;
        SPD_100:  mode_d = MODE_MII100;
        SPD_10:   mode_d = ser_ten_q ? MODE_SERIAL : MODE_MII10;
        default:  mode_d = MODE_MII10;
      endcase
    end
  end

  // width and clock rate per mode, registered for clean outputs
  // eight bits 125 MHz
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mac_mode_o  <= MODE_MII10;
      mac_width_o <= W_NIB;
      mac_rate_o  <= RATE_2M5;
    end else begin
      mac_mode_o <= mode_d;
      unique case (mode_d)
        MODE_GMII: begin
          mac_width_o <= W_BYTE;
          mac_rate_o  <= RATE_125M;
        end
        MODE_MII100: begin
          mac_width_o <= W_NIB;
          mac_rate_o  <= RATE_25M;
        end
        MODE_SERIAL: begin
          mac_width_o <= W_SER;
          mac_rate_o  <= RATE_10M;
        end
        MODE_TBI: begin
          mac_width_o <= W_TEN;
          mac_rate_o  <= RATE_125M;
        end
        default: begin
          mac_width_o <= W_NIB;
          mac_rate_o  <= RATE_2M5;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  logic [31:0] rd_d;

  // unmapped addresses read as zero
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (reg_addr_i)
      ADDR_CTRL: begin
        rd_d[CTRL_HUNT_EN] = hunt_en_q;
      end
      ADDR_STATUS: begin
        rd_d[ST_LINK]            = link_q;
        rd_d[ST_SPEED +: 2]      = speed_q;
        rd_d[ST_DUPLEX]          = duplex_q;
        rd_d[ST_MDIX]            = mdix;
        rd_d[ST_MODE +: 3]       = mac_mode_o;
        rd_d[ST_IN_RESET]        = phy_reset_o;
        rd_d[ST_LINK_CHG]        = link_chg_q;
      end
      ADDR_CONFIG: begin
        rd_d[CFG_TEN_BIT]        = ten_bit_q;
        rd_d[CFG_SER_TEN]        = ser_ten_q;
        rd_d[CFG_XMODE +: 2]     = xmode_q;
      end
      default: begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_re_i) begin
      reg_rdata_o <= rd_d;
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

endmodule : pmcs_top

`default_nettype wire

/* File: dv/pmcs_top_assertions.sv */
// concurrent checks on the mode select and crossover block ports
`timescale 1ns/1ns
`default_nettype none
module pmcs_top_assertions
  import pmcs_pkg::*;
#(
  parameter int HUNT_CYCLES = HUNT_CYC
) (
  // clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rstn_i,
  // watched inputs
  input wire logic        link_up_i,
  input wire logic [1:0]  link_speed_i,
  input wire logic        reg_re_i,
  // watched outputs
  input wire logic [31:0] reg_rdata_o,
  input wire logic [2:0]  mac_mode_o,
  input wire logic [3:0]  mac_width_o,
  input wire logic [1:0]  mac_rate_o,
  input wire logic        pair_a_tx_o,
  input wire logic        pair_a_rx_o,
  input wire logic        pair_b_tx_o,
  input wire logic        pair_b_rx_o,
  input wire logic        pair_cd_on_o,
  input wire logic        phy_reset_o,
  input wire logic        an_restart_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  // hold length counter, saturating so a stuck hold cannot wrap into range
  logic [7:0] hold_cnt_q;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hold_cnt_q <= 8'h00;
    end else if (!phy_reset_o) begin
      hold_cnt_q <= 8'h00;
    end else if (hold_cnt_q != 8'hFF) begin
      hold_cnt_q <= hold_cnt_q + 8'h01;
    end
  end

  sequence s_hold2; phy_reset_o [*2]; endsequence
  sequence s_down3; (!link_up_i) [*3]; endsequence
  // the restart cycle is not yet running, so it cannot start the window
  sequence s_fast3;
    (link_up_i && link_speed_i == SPD_100 && !phy_reset_o && !an_restart_o) [*3];
  endsequence
  sequence s_gig2; (mac_mode_o == MODE_GMII && !phy_reset_o) [*2]; endsequence
  sequence s_slow2; (mac_mode_o == MODE_MII100 && !phy_reset_o) [*2]; endsequence

  property p_gmii_fmt; mac_mode_o == MODE_GMII |-> mac_width_o == W_BYTE && mac_rate_o == RATE_125M;
  endproperty
  a_gmii_fmt: assert property (p_gmii_fmt) else $error("gigabit width or rate wrong");
  property p_nib_fmt; mac_mode_o == MODE_MII100 |-> mac_width_o == W_NIB && mac_rate_o == RATE_25M;
  endproperty
  a_nib_fmt: assert property (p_nib_fmt) else $error("hundred width or rate wrong");
  property p_ten_fmt;
    (mac_mode_o == MODE_MII10 |-> mac_width_o == W_NIB && mac_rate_o == RATE_2M5) and
    (mac_mode_o == MODE_SERIAL |-> mac_width_o == W_SER && mac_rate_o == RATE_10M);
  endproperty
  a_ten_fmt: assert property (p_ten_fmt) else $error("ten width or rate wrong");
  property p_tbi_fmt; mac_mode_o == MODE_TBI |-> mac_width_o == W_TEN && mac_rate_o == RATE_125M;
  endproperty
  a_tbi_fmt: assert property (p_tbi_fmt) else $error("ten-bit width or rate wrong");
  property p_no_link; s_down3 ##0 mac_mode_o != MODE_TBI |-> mac_mode_o == MODE_MII10; endproperty
  a_no_link: assert property (p_no_link) else $error("no link but not ten nibble mode");
  property p_speed_mode; s_fast3 ##0 mac_mode_o != MODE_TBI |-> mac_mode_o == MODE_MII100;
  endproperty
  a_speed_mode: assert property (p_speed_mode) else $error("mode does not follow speed");
  property p_hold_pairs;
    s_hold2 |-> !(pair_a_tx_o | pair_a_rx_o | pair_b_tx_o | pair_b_rx_o | pair_cd_on_o);
  endproperty
  a_hold_pairs: assert property (p_hold_pairs) else $error("pairs active in hold");
  property p_gig_pairs;
    s_gig2 |-> pair_a_tx_o && pair_a_rx_o && pair_b_tx_o && pair_b_rx_o && pair_cd_on_o;
  endproperty
  a_gig_pairs: assert property (p_gig_pairs) else $error("gigabit pairs not all on");
  property p_slow_pairs;
    s_slow2 |-> !pair_cd_on_o && pair_a_tx_o == pair_b_rx_o && pair_a_rx_o == pair_b_tx_o
      && pair_a_tx_o != pair_a_rx_o;
  endproperty
  a_slow_pairs: assert property (p_slow_pairs) else $error("slow link pair map wrong");
  property p_restart; $fell(phy_reset_o) |-> ##[0:1] an_restart_o ##1 !an_restart_o; endproperty
  a_restart: assert property (p_restart) else $error("no single restart pulse");
  property p_hold_len; $fell(phy_reset_o) |-> hold_cnt_q >= 8'h30 && hold_cnt_q <= 8'h34;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("hold length wrong");
  property p_rdata_idle; !$past(reg_re_i) |-> reg_rdata_o == 32'h0000_0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
endmodule : pmcs_top_assertions

bind pmcs_top pmcs_top_assertions #(.HUNT_CYCLES(HUNT_CYCLES)) u_chk (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link_up_i(link_up_i),
  .link_speed_i(link_speed_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
  .mac_mode_o(mac_mode_o), .mac_width_o(mac_width_o), .mac_rate_o(mac_rate_o),
  .pair_a_tx_o(pair_a_tx_o), .pair_a_rx_o(pair_a_rx_o), .pair_b_tx_o(pair_b_tx_o),
  .pair_b_rx_o(pair_b_rx_o), .pair_cd_on_o(pair_cd_on_o), .phy_reset_o(phy_reset_o),
  .an_restart_o(an_restart_o)
);
`default_nettype wire

/* File: dv/pmcs_line_model.sv */
// far side model: resolved link and line activity clock
`timescale 1ns/1ns
`default_nettype none
module pmcs_line_model #(
  parameter bit SLOW = 1'b1
) (
  // clock
  input  wire logic       clk_sys_i,
  // requests from the bench
  input  wire logic       up_req_i,
  input  wire logic [1:0] speed_req_i,
  input  wire logic       duplex_req_i,
  input  wire logic       act_req_i,
  // toward the block
  output logic            link_up_o,
  output logic      [1:0] link_speed_o,
  output logic            link_duplex_o,
  output logic            rx_pair_clk_o
);
  logic [3:0] s1_q = 4'h0;
  logic [3:0] s2_q = 4'h0;
  logic       clk_q = 1'b0;
  always @(posedge clk_sys_i) begin
    s1_q <= {up_req_i, speed_req_i, duplex_req_i};
    s2_q <= s1_q;
  end
  assign {link_up_o, link_speed_o, link_duplex_o} = SLOW ? s2_q : s1_q;
  // line clock runs only while active; phase unrelated to the system clock
  initial begin
    #7;
    forever begin
      #160;
      clk_q = act_req_i ? ~clk_q : 1'b0;
    end
  end
  assign rx_pair_clk_o = clk_q;
endmodule : pmcs_line_model
`default_nettype wire

/* File: dv/pmcs_top_bench.sv */
// self-checking bench for the mode select and crossover block
`timescale 1ns/1ns
`default_nettype none
module pmcs_top_bench;
  import pmcs_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        tb_i = 1'b0, ser_i = 1'b1, xsel_i = 1'b0, xopen_i = 1'b0;
  logic        up_q = 1'b0, dup_q = 1'b1, act_q = 1'b0;
  logic [1:0]  spd_q = 2'b00;
  logic        rx_clk, l_up, l_dup;
  logic [1:0]  l_spd;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic        reg_we_i = 1'b0, reg_re_i = 1'b0;
  logic [31:0] reg_rdata_o, d, m;
  logic [2:0]  mac_mode_o;
  logic [3:0]  mac_width_o;
  logic [1:0]  mac_rate_o;
  logic        a_tx, a_rx, b_tx, b_rx, cd_on, phy_reset_o, an_restart_o;
  int          n_errors = 0, comparisons = 0;
  pmcs_speed_t spds[3] = '{SPD_10, SPD_100, SPD_1000};
  pmcs_mode_t  modes[3] = '{MODE_SERIAL, MODE_MII100, MODE_GMII};
  logic [3:0]  wids[3] = '{W_SER, W_NIB, W_BYTE};
  pmcs_rate_t  rates[3] = '{RATE_10M, RATE_25M, RATE_125M};

  // 25 MHz system clock
  always #20 clk_sys_i = ~clk_sys_i;

  pmcs_line_model u_line (.clk_sys_i(clk_sys_i), .up_req_i(up_q), .speed_req_i(spd_q),
    .duplex_req_i(dup_q), .act_req_i(act_q), .link_up_o(l_up), .link_speed_o(l_spd),
    .link_duplex_o(l_dup), .rx_pair_clk_o(rx_clk));

  // short hunt window keeps the auto crossover run brief
  pmcs_top #(.HUNT_CYCLES(64)) dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .ten_bit_config_strap_i(tb_i), .serial_ten_select_i(ser_i), .crossover_select_i(xsel_i),
    .crossover_open_i(xopen_i), .rx_pair_clk_i(rx_clk), .link_up_i(l_up),
    .link_speed_i(l_spd), .link_duplex_i(l_dup), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .mac_mode_o(mac_mode_o), .mac_width_o(mac_width_o),
    .mac_rate_o(mac_rate_o), .pair_a_tx_o(a_tx), .pair_a_rx_o(a_rx), .pair_b_tx_o(b_tx),
    .pair_b_rx_o(b_rx), .pair_cd_on_o(cd_on), .phy_reset_o(phy_reset_o),
    .an_restart_o(an_restart_o));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic finish_test;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check_val

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_sys_i);
    reg_we_i <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] msk);
    @(posedge clk_sys_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_re_i <= 1'b0;
    #1 d = reg_rdata_o;
    check_val(nm, e, d & msk);
  endtask : rd_chk

  task automatic wait_hold(input logic lvl);
    for (int i = 0; i < 200; i++) begin
      @(posedge clk_sys_i);
      #1;
      if (phy_reset_o === lvl) return;
    end
    n_errors++;
    $display("[FAIL] hold wait expected %b seen %b", lvl, phy_reset_o);
    finish_test();
  endtask : wait_hold

  task automatic set_link(input logic up, input logic [1:0] s);
    @(posedge clk_sys_i);
    up_q <= up;
    spd_q <= s;
    cyc(6);
  endtask : set_link

  task automatic chk_mode(input logic [2:0] md, input logic [3:0] w, input logic [1:0] r);
    check_val("mode", md, mac_mode_o);
    check_val("width", w, mac_width_o);
    check_val("rate", r, mac_rate_o);
  endtask : chk_mode

  task automatic chk_pairs(input logic [4:0] e);
    check_val("pairs", e, {a_tx, a_rx, b_tx, b_rx, cd_on});
  endtask : chk_pairs

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    cyc(8);
    rstn_i <= 1'b1;
    wait_hold(1'b0);
    rd_chk("config", ADDR_CONFIG, 32'h0000_0002, 32'hFFFF_FFFF);
    rd_chk("ctrl", ADDR_CTRL, 32'h0000_0002, 32'hFFFF_FFFF);
    rd_chk("unmapped", 8'h0C, 32'h0000_0000, 32'hFFFF_FFFF);
    chk_mode(MODE_MII10, W_NIB, RATE_2M5);
    chk_pairs(5'b10010);
    for (int i = 0; i < 3; i++) begin
      set_link(1'b1, spds[i]);
      chk_mode(modes[i], wids[i], rates[i]);
      rd_chk("status", ADDR_STATUS, {24'h0, modes[i], 2'b01, spds[i], 1'b1}, 32'h0FF);
    end
    chk_pairs(5'b11111);
    rd_chk("link chg", ADDR_STATUS, 32'h0000_0200, 32'h0000_0200);
    reg_wr(ADDR_STATUS, 32'h0000_0200);
    rd_chk("chg clear", ADDR_STATUS, 32'h0000_0000, 32'h0000_0200);
    xsel_i <= 1'b1;
    wait_hold(1'b1);
    wait_hold(1'b0);
    cyc(6);
    chk_pairs(5'b11111);
    set_link(1'b1, SPD_100);
    chk_pairs(5'b01100);
    rd_chk("mdix", ADDR_STATUS, 32'h0000_0010, 32'h0000_0010);
    ser_i <= 1'b0;
    reg_wr(ADDR_CTRL, 32'h0000_0003);
    #1 check_val("soft hold", 1'b1, phy_reset_o);
    wait_hold(1'b0);
    rd_chk("config", ADDR_CONFIG, 32'h0000_0006, 32'hFFFF_FFFF);
    set_link(1'b0, SPD_10);
    xopen_i <= 1'b1;
    wait_hold(1'b1);
    wait_hold(1'b0);
    rd_chk("config", ADDR_CONFIG, 32'h0000_000A, 32'hFFFF_FFFF);
    rd_chk("mdix", ADDR_STATUS, 32'h0, 32'h10);
    m = d ^ 32'h0000_0010;
    cyc(80);
    rd_chk("hunt toggle", ADDR_STATUS, m & 32'h10, 32'h10);
    act_q <= 1'b1;
    cyc(10);
    rd_chk("mdix", ADDR_STATUS, 32'h10, 32'h10);
    m = d;
    cyc(150);
    rd_chk("hunt hold", ADDR_STATUS, m & 32'h10, 32'h10);
    act_q <= 1'b0;
    reg_wr(ADDR_CTRL, 32'h0000_0000);
    cyc(3);
    rd_chk("hunt off", ADDR_STATUS, 32'h0000_0000, 32'h0000_0010);
    rstn_i <= 1'b0;
    tb_i <= 1'b1;
    xopen_i <= 1'b0;
    xsel_i <= 1'b0;
    cyc(8);
    rstn_i <= 1'b1;
    wait_hold(1'b0);
    rd_chk("config", ADDR_CONFIG, 32'h0000_0001, 32'hFFFF_FFFF);
    chk_mode(MODE_TBI, W_TEN, RATE_125M);
    set_link(1'b1, SPD_100);
    chk_mode(MODE_TBI, W_TEN, RATE_125M);
    rd_chk("tbi slow", ADDR_STATUS, 32'h0000_0000, 32'h0000_0001);
    set_link(1'b1, SPD_1000);
    rd_chk("tbi gig", ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
    finish_test();
  end
endmodule : pmcs_top_bench
`default_nettype wire
